// file: core/acr_bank.sv
// Configuration register bank with averager, conversion timer and CRC fault handling
`timescale 1ns/1ps
module acr_bank #(
	parameter int TICK_HS = acr_pkg::HS_TICK_CYC,
	parameter int TICK_LP = acr_pkg::LP_TICK_CYC
) (
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	// Register port from the serial front end
	input  wire logic [7:0]         reg_addr,
	input  wire logic [7:0]         reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic [7:0]              reg_rdata,
	// Fault event from the interface CRC checker
	input  wire logic               crc_fault_evt,
	// Conversion control
	input  wire logic               host_conv_req,
	output logic                    conv_start,
	input  wire logic               sample_valid,
	input  wire acr_pkg::acr_sample_s sample,
	output logic                    result_valid,
	output acr_pkg::acr_word_s      result,
	// Configuration seen by the rest of the device
	output logic [1:0]              serial_mode_select,
	output logic                    oscillator_choice,
	output logic [7:0]              channel_is_digital,
	output logic [7:0]              digital_dir,
	output logic                    sequencing_enable,
	output logic                    input_crc_fault_flag
);
	localparam int PW = 17;
	// Refuse ticks the prescaler cannot count
	if (TICK_HS < 1 || TICK_LP < 1 || TICK_HS >= 2**PW || TICK_LP >= 2**PW) begin : g_bad
		$error("acr_bank: tick counts out of range");
	end

	// Address match helper
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction : hit

	// Registers
	logic [7:0]  fmt_r;                 // Output format
	logic [7:0]  avg_r;                 // Averaging ratio
	logic [7:0]  opm_r;                 // Operating mode
	logic [7:0]  pin_r;                 // Channel function
	logic [7:0]  dir_r;                 // Digital direction
	logic [7:0]  save_r;                // Pin setting held across a forced period
	logic        flag_r;                // Sticky CRC fault
	logic        force_r;               // All channels forced analog
	logic [7:0]  rdata_r;               // Read data
	logic [PW-1:0] presc_r;             // Oscillator tick prescaler
	logic [3:0]  div_r;                 // Divider tick counter
	logic        start_r;               // Conversion start pulse
	acr_pkg::acr_avg_e st_r;            // Averager state
	logic [18:0] acc_r;                 // Running sum, 12 + 7 bits
	logic [6:0]  cnt_r;                 // Samples taken so far
	logic        res_vld_r;             // Result pulse
	acr_pkg::acr_word_s res_r;          // Result word

	// Decode of writes
	wire wr_stat = reg_wr && hit(reg_addr, acr_pkg::ADDR_STATUS);
	wire wr_fmt  = reg_wr && hit(reg_addr, acr_pkg::ADDR_FORMAT);
	wire wr_avg  = reg_wr && hit(reg_addr, acr_pkg::ADDR_AVERAGE);
	wire wr_opm  = reg_wr && hit(reg_addr, acr_pkg::ADDR_OPMODE);
	wire wr_pin  = reg_wr && hit(reg_addr, acr_pkg::ADDR_PINFUNC);
	wire wr_dir  = reg_wr && hit(reg_addr, acr_pkg::ADDR_DIGDIR);

	// Field views
	wire       pat_en  = fmt_r[acr_pkg::FMT_PATTERN_BIT];
	wire [1:0] append  = fmt_r[acr_pkg::FMT_APPEND_LSB +: 2];
	wire [2:0] ratio   = avg_r[2:0];
	wire       halt    = opm_r[acr_pkg::OPM_HALT_BIT];
	wire [1:0] mode    = opm_r[acr_pkg::OPM_MODE_LSB +: 2];
	wire       osc_lp  = opm_r[acr_pkg::OPM_OSC_BIT];
	wire [3:0] clk_div = opm_r[acr_pkg::OPM_DIV_LSB +: 4];

	// Reserved bits masked off on write
	wire [7:0] fmt_nxt = wr_fmt ? (reg_wdata & acr_pkg::FORMAT_WMASK) : fmt_r;
	wire [7:0] avg_nxt = wr_avg ? (reg_wdata & acr_pkg::AVERAGE_WMASK) : avg_r;
	// Reserved mode codes keep the old mode
	wire       mode_ok = (reg_wdata[acr_pkg::OPM_MODE_LSB +: 2] == acr_pkg::MODE_MANUAL)
		|| (reg_wdata[acr_pkg::OPM_MODE_LSB +: 2] == acr_pkg::MODE_AUTO);
	wire [1:0] mode_w  = mode_ok ? reg_wdata[acr_pkg::OPM_MODE_LSB +: 2] : mode;
	wire [7:0] opm_nxt = wr_opm ? {reg_wdata[7], mode_w, reg_wdata[4:0]} : opm_r;

	// Fault flag: a new fault beats a clear in the same cycle
	wire clr_flag  = wr_stat && reg_wdata[acr_pkg::STAT_CRC_BIT];
	wire flag_nxt  = crc_fault_evt || (flag_r && !clr_flag);
	// Forcing starts only with the halt bit set; ends with the flag
	// A repeat fault while forced must not overwrite the saved pin copy
	wire enter     = crc_fault_evt && halt && !force_r;
	wire force_nxt = (crc_fault_evt && halt) || (force_r && flag_nxt);
	wire restore   = force_r && !force_nxt;
	// Pin setting frozen while forced so the saved copy stays valid
	wire [7:0] pin_nxt = restore ? save_r
		: ((wr_pin && !force_r) ? reg_wdata : pin_r);
	wire [7:0] save_nxt = enter ? pin_r : save_r;

	// Read mux; unmapped offsets read zero
	// Only the fault flag shows in status; every other bit reads zero
	wire [7:0] stat_rd = {7'h00, flag_r} << acr_pkg::STAT_CRC_BIT;
	wire [7:0] rd_mux =
		hit(reg_addr, acr_pkg::ADDR_STATUS)  ? stat_rd :
		hit(reg_addr, acr_pkg::ADDR_FORMAT)  ? fmt_r   :
		hit(reg_addr, acr_pkg::ADDR_AVERAGE) ? avg_r   :
		hit(reg_addr, acr_pkg::ADDR_OPMODE)  ? opm_r   :
		hit(reg_addr, acr_pkg::ADDR_PINFUNC) ? pin_r   :
		hit(reg_addr, acr_pkg::ADDR_DIGDIR)  ? dir_r   : 8'h00;

	// Register file
	// Read data is registered and held, so the serial side may fetch it late
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fmt_r   <= acr_pkg::RST_FORMAT;
			avg_r   <= acr_pkg::RST_AVERAGE;
			opm_r   <= acr_pkg::RST_OPMODE;
			pin_r   <= acr_pkg::RST_PINFUNC;
			dir_r   <= acr_pkg::RST_DIGDIR;
			save_r  <= acr_pkg::RST_PINFUNC;
			flag_r  <= 1'b0;
			force_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			fmt_r   <= fmt_nxt;
			avg_r   <= avg_nxt;
			opm_r   <= opm_nxt;
			pin_r   <= pin_nxt;
			dir_r   <= wr_dir ? reg_wdata : dir_r;
			save_r  <= save_nxt;
			flag_r  <= flag_nxt;
			force_r <= force_nxt;
			rdata_r <= reg_rd ? rd_mux : rdata_r;
		end
	end

	// Conversion timer: low-power tick is slower, divider stretches it
	wire [PW-1:0] tick_len = osc_lp ? PW'(TICK_LP) : PW'(TICK_HS);
	wire          auto_on  = (mode == acr_pkg::MODE_AUTO) && !force_r;
	// Compare with >=: a switch to the shorter tick must not strand the prescaler
	wire          tick     = (presc_r >= tick_len - PW'(1));
	// Divider compared with >= so a smaller divider takes effect at once
	wire          fire     = tick && (div_r >= clk_div);
	wire [PW-1:0] presc_nxt = (!auto_on || tick) ? '0 : presc_r + PW'(1);
	wire [3:0]    div_nxt  = (!auto_on || fire) ? 4'h0 : (tick ? div_r + 4'h1 : div_r);
	// Manual starts follow host requests only; suspended while forced
	wire start_nxt = !force_r && (((mode == acr_pkg::MODE_MANUAL) && host_conv_req)
		|| (auto_on && fire));

	// Timer flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			presc_r <= '0;
			div_r   <= 4'h0;
			start_r <= 1'b0;
		end else begin
			presc_r <= presc_nxt;
			div_r   <= div_nxt;
			start_r <= start_nxt;
		end
	end

	// Averager: sum 2^ratio samples then shift down
	// 19-bit sum so 128 full-scale codes cannot overflow
	wire [18:0] sum_all  = acc_r + {7'h00, sample.code};
	wire [6:0]  cnt_last = 7'((8'h01 << ratio) - 8'h01);
	wire        last     = sample_valid && (cnt_r == cnt_last);
	wire [18:0] avg_val  = sum_all >> ratio;
	// Pattern overrides data; tail per append code, reserved gives none
	wire [11:0] out_code = pat_en ? acr_pkg::TEST_CODE : avg_val[11:0];
	wire [3:0]  out_tail = (append == acr_pkg::APPEND_CHID)  ? sample.chid  :
		(append == acr_pkg::APPEND_FLAGS) ? sample.flags : 4'h0;
	acr_pkg::acr_avg_e st_nxt;
	// Ratio change restarts the sum so no mixed average escapes
	always_comb begin
		case (st_r)
			acr_pkg::ACR_IDLE:    st_nxt = (sample_valid && !last && !wr_avg)
				? acr_pkg::ACR_COLLECT : acr_pkg::ACR_IDLE;
			acr_pkg::ACR_COLLECT: st_nxt = (last || wr_avg)
				? acr_pkg::ACR_IDLE : acr_pkg::ACR_COLLECT;
			default:              st_nxt = acr_pkg::ACR_IDLE;
		endcase
	end

	// Averager flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r      <= acr_pkg::ACR_IDLE;
			acc_r     <= '0;
			cnt_r     <= 7'h00;
			res_vld_r <= 1'b0;
			res_r     <= '0;
		end else begin
			st_r      <= st_nxt;
			acc_r     <= (st_nxt == acr_pkg::ACR_COLLECT && sample_valid) ? sum_all
				: ((st_nxt == acr_pkg::ACR_IDLE) ? '0 : acc_r);
			cnt_r     <= (st_nxt == acr_pkg::ACR_IDLE) ? 7'h00
				: (sample_valid ? cnt_r + 7'h01 : cnt_r);
			res_vld_r <= last && !wr_avg;
			res_r     <= (last && !wr_avg) ? {out_code, out_tail} : res_r;
		end
	end

	// Outputs
	assign reg_rdata            = rdata_r;
	assign conv_start           = start_r;
	assign result_valid         = res_vld_r;
	assign result               = res_r;
	assign serial_mode_select   = fmt_r[acr_pkg::FMT_SERIAL_LSB +: 2];
	assign oscillator_choice    = osc_lp;
	// Gate rather than overwrite, so the register keeps the pre-fault setting
	assign channel_is_digital   = force_r ? 8'h00 : pin_r;
	assign digital_dir          = dir_r;
	assign sequencing_enable    = !force_r;
	assign input_crc_fault_flag = flag_r;

	// Checks
	property p_tail(logic [1:0] code, logic [3:0] want);
		@(posedge core_clk) disable iff (!rst_n)
		res_vld_r && $past(append) == code |-> res_r.tail == want;
	endproperty
	// Readout format checks
	a_fixed_pattern: assert property (@(posedge core_clk) disable iff (!rst_n)
		res_vld_r && $past(pat_en) |-> res_r.code == acr_pkg::TEST_CODE)
		else $error("pattern readout wrong");
	a_normal_data: assert property (@(posedge core_clk) disable iff (!rst_n)
		res_vld_r && !$past(pat_en) && $past(ratio) == 3'h0
		|-> res_r.code == $past(sample.code))
		else $error("plain readout wrong");
	a_tail_none: assert property (p_tail(2'h0, 4'h0))
		else $error("tail not empty");
	a_tail_chid: assert property (p_tail(2'h1, $past(sample.chid)))
		else $error("tail lacks channel id");
	a_tail_flags: assert property (p_tail(2'h2, $past(sample.flags)))
		else $error("tail lacks flags");
	// Configuration field checks
	a_serial_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_fmt |=> serial_mode_select == $past(reg_wdata[1:0]))
		else $error("serial mode not taken");
	a_osc_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_opm |=> oscillator_choice == $past(reg_wdata[acr_pkg::OPM_OSC_BIT]))
		else $error("oscillator choice not taken");
	a_avg_reserved: assert property (@(posedge core_clk) disable iff (!rst_n)
		reg_rd && hit(reg_addr, acr_pkg::ADDR_AVERAGE) |=> reg_rdata[7:3] == 5'h00)
		else $error("averaging reserved bits nonzero");
	a_sample_count: assert property (@(posedge core_clk) disable iff (!rst_n)
		res_vld_r |-> 8'($past(cnt_r)) + 8'h01 == (8'h01 << $past(ratio)))
		else $error("wrong sample count");
	// CRC fault handling checks
	a_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
		crc_fault_evt |=> flag_r)
		else $error("fault did not set flag");
	a_save_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
		enter |=> save_r == $past(pin_r))
		else $error("pin setting not saved");
	a_pin_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
		force_r && !restore |=> $stable(pin_r))
		else $error("pin setting moved while forced");
	a_crc_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
		crc_fault_evt && !halt && !force_r && !wr_pin
		|=> channel_is_digital == $past(pin_r) && sequencing_enable)
		else $error("pins changed without halt");
	a_crc_force: assert property (@(posedge core_clk) disable iff (!rst_n)
		crc_fault_evt && halt |=> channel_is_digital == 8'h00 && !sequencing_enable
		##1 !conv_start)
		else $error("fault did not force analog");
	a_crc_restore: assert property (@(posedge core_clk) disable iff (!rst_n)
		force_r && clr_flag && !crc_fault_evt
		|=> sequencing_enable && channel_is_digital == $past(save_r))
		else $error("pins not restored");
	// Conversion start checks
	a_manual_start: assert property (@(posedge core_clk) disable iff (!rst_n)
		!host_conv_req && mode == acr_pkg::MODE_MANUAL |=> !conv_start)
		else $error("manual start without request");
	a_auto_period: assert property (@(posedge core_clk) disable iff (!rst_n)
		fire && auto_on |=> conv_start)
		else $error("autonomous start missing");
	// Register access checks
	a_pin_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_pin && !force_r |=> pin_r == $past(reg_wdata))
		else $error("pin write lost");
	a_status_read: assert property (@(posedge core_clk) disable iff (!rst_n)
		reg_rd && hit(reg_addr, acr_pkg::ADDR_STATUS)
		|=> reg_rdata == ({7'h00, $past(flag_r)} << acr_pkg::STAT_CRC_BIT))
		else $error("status read wrong");
	a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		reg_rd && hit(reg_addr, acr_pkg::ADDR_FORMAT)
		|=> reg_rdata[6] == 1'b0 && reg_rdata[3:2] == 2'h0)
		else $error("reserved bits read nonzero");
	a_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
		flag_r && !clr_flag |=> flag_r)
		else $error("flag dropped");
	a_mode_guard: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_opm && reg_wdata[6] |=> mode == $past(mode))
		else $error("reserved mode accepted");
	// Scenario covers
	c_pattern: cover property (@(posedge core_clk) res_vld_r && pat_en);
	c_tail_flags: cover property (@(posedge core_clk) res_vld_r && append == acr_pkg::APPEND_FLAGS);
	c_auto: cover property (@(posedge core_clk) auto_on && conv_start);
	c_restore: cover property (@(posedge core_clk) restore);
	c_avg128: cover property (@(posedge core_clk) res_vld_r && ratio == 3'h7);
endmodule : acr_bank

// file: core/acr_pkg.sv
// Constants, types and layout for the ADC configuration register bank
package acr_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_STATUS   = 8'h00;
	localparam logic [7:0] ADDR_FORMAT   = 8'h02;
	localparam logic [7:0] ADDR_AVERAGE  = 8'h03;
	localparam logic [7:0] ADDR_OPMODE   = 8'h04;
	localparam logic [7:0] ADDR_PINFUNC  = 8'h05;
	localparam logic [7:0] ADDR_DIGDIR   = 8'h07;
	// Reset values
	localparam logic [7:0] RST_FORMAT    = 8'h00;
	localparam logic [7:0] RST_AVERAGE   = 8'h00;
	localparam logic [7:0] RST_OPMODE    = 8'h00;
	localparam logic [7:0] RST_PINFUNC   = 8'h00;
	localparam logic [7:0] RST_DIGDIR    = 8'h00;
	// Writable bits; everything else is reserved
	localparam logic [7:0] FORMAT_WMASK  = 8'hB3;
	localparam logic [7:0] AVERAGE_WMASK = 8'h07;
	// Field positions
	localparam int FMT_PATTERN_BIT = 7;
	localparam int FMT_APPEND_LSB  = 4;
	localparam int FMT_SERIAL_LSB  = 0;
	localparam int OPM_HALT_BIT    = 7;
	localparam int OPM_MODE_LSB    = 5;
	localparam int OPM_OSC_BIT     = 4;
	localparam int OPM_DIV_LSB     = 0;
	localparam int STAT_CRC_BIT    = 1;
	// Encodings
	localparam logic [11:0] TEST_CODE    = 12'hA5A;
	localparam logic [1:0]  APPEND_NONE  = 2'h0;
	localparam logic [1:0]  APPEND_CHID  = 2'h1;
	localparam logic [1:0]  APPEND_FLAGS = 2'h2;
	localparam logic [1:0]  MODE_MANUAL  = 2'h0;
	localparam logic [1:0]  MODE_AUTO    = 2'h1;
	// Timing: base tick of each oscillator
	localparam int CLK_MHZ      = 40;
	localparam int HS_TICK_NS   = 1000;
	localparam int LP_TICK_NS   = 100000;
	localparam int HS_TICK_CYC  = (HS_TICK_NS * CLK_MHZ) / 1000;
	localparam int LP_TICK_CYC  = (LP_TICK_NS * CLK_MHZ) / 1000;
	// Averager states, Gray along idle to collecting
	typedef enum logic [1:0] {
		ACR_IDLE    = 2'b00,
		ACR_COLLECT = 2'b01
	} acr_avg_e;
	// One conversion from the converter core
	typedef struct packed {
		logic [11:0] code;
		logic [3:0]  chid;
		logic [3:0]  flags;
	} acr_sample_s;
	// One readout word: data then appended tail
	typedef struct packed {
		logic [11:0] code;
		logic [3:0]  tail;
	} acr_word_s;
endpackage : acr_pkg

// file: tb/acr_conv_model.sv
// Behavioural converter core that answers conversion starts with samples
`timescale 1ns/1ps
module acr_conv_model #(
	parameter logic [11:0] BASE = 12'h3C4
) (
	// Clock and reset
	input  wire logic          core_clk,
	input  wire logic          rst_n,
	// Conversion handshake
	input  wire logic          conv_start,
	output logic               sample_valid,
	output acr_pkg::acr_sample_s sample
);
	logic [1:0] dly_r; // Start-to-sample latency line
	logic       alt_r; // Alternates the code so averages are visible

	// Two-cycle conversion latency, alternate code per sample
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dly_r <= 2'b00;
			alt_r <= 1'b0;
		end else begin
			dly_r <= {dly_r[0], conv_start};
			if (dly_r[1]) begin
				alt_r <= ~alt_r;
			end
		end
	end

	assign sample_valid = dly_r[1];
	// Outside a valid cycle show inverted values, never the stale sample
	assign sample.code  = sample_valid ? (alt_r ? BASE + 12'h002 : BASE) : ~BASE;
	assign sample.chid  = sample_valid ? 4'h5 : 4'hA;
	assign sample.flags = sample_valid ? 4'hA : 4'h5;
endmodule : acr_conv_model

// file: tb/acr_bank_test.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module acr_bank_test;
	logic                 core_clk, rst_n, reg_wr, reg_rd, crc_fault_evt, host_conv_req;
	logic [7:0]           reg_addr, reg_wdata, reg_rdata, channel_is_digital, digital_dir;
	logic                 conv_start, sample_valid, result_valid, oscillator_choice;
	logic                 sequencing_enable, input_crc_fault_flag;
	logic [1:0]           serial_mode_select;
	acr_pkg::acr_sample_s sample, last;
	acr_pkg::acr_word_s   result, w;
	int                   num_errors, samples_checked, n;
	logic [11:0]          ecode;
	logic [3:0]           etail;
	logic [7:0]           fmt;

	// Short ticks keep autonomous periods a few cycles long
	acr_bank #(.TICK_HS(2), .TICK_LP(3)) dut (.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .crc_fault_evt(crc_fault_evt), .host_conv_req(host_conv_req),
		.conv_start(conv_start), .sample_valid(sample_valid), .sample(sample),
		.result_valid(result_valid), .result(result), .serial_mode_select(serial_mode_select),
		.oscillator_choice(oscillator_choice), .channel_is_digital(channel_is_digital),
		.digital_dir(digital_dir), .sequencing_enable(sequencing_enable),
		.input_crc_fault_flag(input_crc_fault_flag));
	acr_conv_model conv (.core_clk(core_clk), .rst_n(rst_n), .conv_start(conv_start),
		.sample_valid(sample_valid), .sample(sample));

	// 40 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Case inequality so an unknown never matches
	task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// One write strobe, then let the update land
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	// Read strobe; data is registered at the sampling edge
	task rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp, "read data");
	endtask : rdc

	// Host conversion request; start follows one cycle later or not at all
	task conv_req(input logic exp);
		@(posedge core_clk);
		host_conv_req <= 1'b1;
		@(posedge core_clk);
		host_conv_req <= 1'b0;
		#1;
		chk(conv_start, exp, "conversion start");
	endtask : conv_req

	// Wait a bounded span for a result, remembering the last sample
	task get_result();
		int i;
		for (i = 0; i < 40; i++) begin
			@(posedge core_clk);
			#1;
			if (sample_valid === 1'b1) last = sample;
			if (result_valid === 1'b1) break;
		end
		w = result;
		if (i == 40) chk(1'b0, 1'b1, "no result");
	endtask : get_result

	// Cycles between two conversion starts; 40 when starts never come
	task period();
		int i;
		for (i = 0; i < 40; i++) begin
			@(posedge core_clk);
			#1;
			if (conv_start === 1'b1) break;
		end
		n = 0;
		for (i = 0; i < 40; i++) begin
			@(posedge core_clk);
			#1;
			n++;
			if (conv_start === 1'b1) break;
		end
	endtask : period

	// One fault pulse, then flag, sequencing and pin state
	task fault(input logic seq, input logic [7:0] pins);
		@(posedge core_clk);
		crc_fault_evt <= 1'b1;
		@(posedge core_clk);
		crc_fault_evt <= 1'b0;
		#1;
		chk({input_crc_fault_flag, sequencing_enable, channel_is_digital}, {1'b1, seq, pins}, "fault");
	endtask : fault

	task end_sim();
		$display("errors %0d, comparisons %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	// Watchdog at 20000 cycles, well beyond the expected run of under a thousand cycles
	initial begin
		#(25 * 20000);
		num_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		end_sim();
	end

	// Main sequence
	initial begin
		{rst_n, reg_wr, reg_rd, crc_fault_evt, host_conv_req} = 5'h00;
		{reg_addr, reg_wdata} = 16'h0000;
		{num_errors, samples_checked} = '0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		// Reset values, unmapped places included
		for (int a = 0; a < 8; a++) rdc(a[7:0], 8'h00);
		wr(8'h02, 8'hFF);
		rdc(8'h02, 8'hB3);
		wr(8'h03, 8'hFF);
		rdc(8'h03, 8'h07);
		for (int m = 0; m < 4; m++) begin
			wr(8'h02, m[7:0]);
			chk(serial_mode_select, m[1:0], "serial mode");
		end
		// Every pattern and append setting, no averaging
		wr(8'h03, 8'h00);
		for (int m = 0; m < 8; m++) begin
			fmt = {m[2], 1'b0, m[1:0], 4'h0};
			wr(8'h02, fmt);
			conv_req(1'b1);
			get_result();
			ecode = m[2] ? acr_pkg::TEST_CODE : last.code;
			etail = (m[1:0] == 2'd1) ? last.chid : (m[1:0] == 2'd2) ? last.flags : 4'h0;
			chk(w, {ecode, etail}, "readout");
		end
		// Averaging ratios 1 to 7 over alternating codes
		wr(8'h02, 8'h00);
		for (int r = 1; r < 8; r++) begin
			wr(8'h03, r[7:0]);
			repeat (1 << r) conv_req(1'b1);
			get_result();
			chk(w, {12'h3C5, 4'h0}, "average");
		end
		// Autonomous timing: tick times divider plus one
		wr(8'h03, 8'h00);
		wr(8'h04, 8'h22);
		period();
		chk(n[15:0], 16'h0006, "fast period");
		wr(8'h04, 8'h32);
		chk(oscillator_choice, 1'b1, "oscillator");
		period();
		chk(n[15:0], 16'h0009, "slow period");
		wr(8'h04, 8'h42);
		period();
		chk(n[15:0], 16'h0006, "reserved mode");
		wr(8'h04, 8'h62);
		rdc(8'h04, 8'h22);
		period();
		chk(n[15:0], 16'h0006, "reserved mode 11");
		wr(8'h04, 8'h00);
		period();
		chk(n[15:0], 16'h0028, "manual idle");
		wr(8'h07, 8'hC3);
		chk(digital_dir, 8'hC3, "direction");
		rdc(8'h07, 8'hC3);
		// Fault with halt clear keeps pins and sequencing
		wr(8'h05, 8'h5A);
		chk(channel_is_digital, 8'h5A, "pins");
		fault(1'b1, 8'h5A);
		rdc(8'h00, 8'h02);
		wr(8'h00, 8'h00);
		chk(input_crc_fault_flag, 1'b1, "flag kept");
		wr(8'h00, 8'h02);
		chk(input_crc_fault_flag, 1'b0, "flag cleared");
		// Fault with halt set forces analog and stops starts
		wr(8'h04, 8'h80);
		fault(1'b0, 8'h00);
		conv_req(1'b0);
		wr(8'h05, 8'hFF);
		wr(8'h00, 8'h02);
		chk({input_crc_fault_flag, sequencing_enable, channel_is_digital}, 10'h15A, "restore");
		conv_req(1'b1);
		end_sim();
	end
endmodule : acr_bank_test
